// file: rtl/sccl_consts.vh
`ifndef SCCL_CONSTS_VH
`define SCCL_CONSTS_VH
// Register word indices, matched against adr_i[5:2]
`define SCCL_ADR_MODE 4'h0
`define SCCL_ADR_RSVD 4'h1
`define SCCL_ADR_PW1 4'h2
`define SCCL_ADR_PW2 4'h3
`define SCCL_ADR_CMD 4'h4
`define SCCL_ADR_TIME1 4'h5
`define SCCL_ADR_TIME2 4'h6
`define SCCL_ADR_STAT 4'h7
`define SCCL_ADR_IRQ 4'h8
`define SCCL_ADR_MASK 4'h9
// Mode byte fields
`define SCCL_B_RADIO 7
`define SCCL_B_PULSE 6
`define SCCL_B_LOCAL 5
// Command register fields
`define SCCL_C_LINE 0
`define SCCL_C_RUN 1
`define SCCL_C_STOP 2
`define SCCL_C_SETT 3
// Pulse width limits in tenths of a second
`define SCCL_PW_MIN 5'h02
`define SCCL_PW_MAX 5'h1e
`define SCCL_PW_SEC 5'h02
`define SCCL_PW_RST 5'h02
// Time counts
`define SCCL_TENTH_CYC 23'h4c4b40
`define SCCL_TICKS_SEC 4'ha
`define SCCL_MAX_SEC 6'h3b
`define SCCL_MAX_HR 5'h17
`define SCCL_DAY_SEC 17'h1517f
`define SCCL_HALF_DAY 17'ha8c0
`endif

// file: rtl/sccl_sync2.v
`timescale 1ns/1ps
`default_nettype none
module sccl_sync2 #(
   parameter W = 4
) (
   input wire clk_i,
   input wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   // Two stage synchroniser
   always @(posedge clk_i) begin
      s1_r <= d_i;
      s2_r <= s1_r;
   end
   assign q_o = s2_r;
endmodule
`default_nettype wire

// file: rtl/sccl_pulse.v
`timescale 1ns/1ps
`default_nettype none
`include "sccl_consts.vh"
module sccl_pulse (
   input wire clk_i,
   input wire rst_i,
   input wire tick_i,
   input wire start_i,
   input wire [4:0] width_i,
   output reg busy_o,
   output reg pol_o
);
   reg [4:0] cnt_r;
   // Width counter, polarity toggles at each start
   always @(posedge clk_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
         pol_o <= 1'b0;
         cnt_r <= 5'h00;
      end else if (start_i && !busy_o) begin
         busy_o <= 1'b1;
         pol_o <= ~pol_o;
         cnt_r <= width_i;
      end else if (busy_o && tick_i) begin
         if (cnt_r == 5'h01) begin
            busy_o <= 1'b0;
         end
         cnt_r <= cnt_r - 5'h01;
      end
   end
endmodule
`default_nettype wire

// file: rtl/sccl_top.v
// Notes on behaviour
// - Mode bit 7 low adds radio fault
// - Any fault releases the alarm relay
// - Relay re-energised when no fault remains
// - Mode bit 6 picks pulses or time code
// - Time-code mode enables each running line
// - Mode bit 5 picks local time or UTC
// - Minute pulse 0.2 to 3.0 s
// - Separate pulse width per minute line
// - Seconds line 0.2 s width unused, minsec_w tied low
// - Run state and line time are readable
// - Stop halts line time and pulses
// - Run advances line time to system time
// - Line time set 00:00:00-23:59:59 on confirm
// - Setting line time puts line running
// - Line time held during faults
`timescale 1ns/1ps
`default_nettype none
`include "sccl_consts.vh"
module sccl_top (
   // System
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [5:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // Time base from host system
   input wire [16:0] sys_utc_i,
   input wire [16:0] sys_local_i,
   input wire sys_sec_i,
   // Fault pins
   input wire radio_fail_i,
   input wire line1_fault_i,
   input wire line2_fault_i,
   input wire supply_fault_i,
   // Line outputs
   output reg [1:0] line_drive_o,
   output reg [1:0] line_pol_o,
   output reg [1:0] timecode_en_o,
   output reg alarm_relay_o,
   output reg irq_o
);
   // Synchronised pins
   wire [3:0] flt_s;
   wire sec_s;
   sccl_sync2 #(.W(5)) u_sync (
      .clk_i(clk_i),
      .d_i({sys_sec_i, supply_fault_i, line2_fault_i, line1_fault_i, radio_fail_i}),
      .q_o({sec_s, flt_s})
   );
   reg [7:0] mode_r;
   reg [7:0] rsvd_r;
   reg [4:0] pw1_r;
   reg [4:0] pw2_r;
   reg [1:0] run_r;
   reg [16:0] lt1_r;
   reg [16:0] lt2_r;
   reg [2:0] irq_st_r;
   reg [2:0] irq_mk_r;
   reg sec_d_r;
   reg [22:0] div_r;
   reg tick_r;
   reg [3:0] tcnt_r;
   reg [1:0] step_r;
   reg fault_d_r;
   wire fault_w;
   wire [1:0] busy_w;
   wire [1:0] pol_w;
   wire acc_w;
   wire [3:0] idx_w;
   wire [16:0] sys_w;
   wire sec_edge_w;
   wire pulse_mode_w;
   wire minsec_w;

   // Clamp a pulse width to legal tenths
   function [4:0] clamp_pw;
      input [4:0] v;
      begin
         if (v < `SCCL_PW_MIN) begin
            clamp_pw = `SCCL_PW_MIN;
         end else if (v > `SCCL_PW_MAX) begin
            clamp_pw = `SCCL_PW_MAX;
         end else begin
            clamp_pw = v;
         end
      end
   endfunction

   // Pack hh:mm:ss BCD-free fields into seconds of day
   function [16:0] hms_to_sec;
      input [4:0] h;
      input [5:0] m;
      input [5:0] s;
      begin
         hms_to_sec = {12'h000, h} * 17'h00e10 + {11'h000, m} * 17'h0003c + {11'h000, s};
      end
   endfunction

   // Next second of day, wrapping at midnight
   function [16:0] inc_sec;
      input [16:0] t;
      begin
         inc_sec = (t == `SCCL_DAY_SEC) ? 17'h00000 : t + 17'h00001;
      end
   endfunction

   assign acc_w = cyc_i && stb_i && !ack_o;
   assign idx_w = adr_i[5:2];
   assign pulse_mode_w = mode_r[`SCCL_B_PULSE];
   assign minsec_w = 1'b0;
   assign sys_w = mode_r[`SCCL_B_LOCAL] ? sys_local_i : sys_utc_i;
   assign sec_edge_w = sec_s && !sec_d_r;
   // Common fault, radio only when not suppressed
   assign fault_w = flt_s[1] || flt_s[2] || flt_s[3] ||
                    (flt_s[0] && !mode_r[`SCCL_B_RADIO]);

   // Bus register writes and line control
   always @(posedge clk_i) begin
      if (rst_i) begin
         mode_r <= 8'h40;
         rsvd_r <= 8'h00;
         pw1_r <= `SCCL_PW_RST;
         pw2_r <= `SCCL_PW_RST;
         run_r <= 2'b00;
         lt1_r <= 17'h00000;
         lt2_r <= 17'h00000;
         irq_mk_r <= 3'h0;
      end else begin
         // Line time catches up once per second when running and fault free
         if (step_r[0]) begin
            lt1_r <= inc_sec(lt1_r);
         end
         if (step_r[1]) begin
            lt2_r <= inc_sec(lt2_r);
         end
         if (acc_w && we_i && sel_i[0]) begin
            case (idx_w)
               `SCCL_ADR_MODE: mode_r <= dat_i[7:0];
               `SCCL_ADR_RSVD: rsvd_r <= dat_i[7:0];
               `SCCL_ADR_PW1: pw1_r <= clamp_pw(dat_i[4:0]);
               `SCCL_ADR_PW2: pw2_r <= clamp_pw(dat_i[4:0]);
               `SCCL_ADR_MASK: irq_mk_r <= dat_i[2:0];
               `SCCL_ADR_CMD: begin
                  if (dat_i[`SCCL_C_STOP]) begin
                     run_r[dat_i[`SCCL_C_LINE]] <= 1'b0;
                  end else if (dat_i[`SCCL_C_RUN]) begin
                     run_r[dat_i[`SCCL_C_LINE]] <= 1'b1;
                  end
                  if (dat_i[`SCCL_C_SETT] && dat_i[28:24] <= `SCCL_MAX_HR &&
                      dat_i[21:16] <= `SCCL_MAX_SEC && dat_i[13:8] <= `SCCL_MAX_SEC) begin
                     if (dat_i[`SCCL_C_LINE]) begin
                        lt2_r <= hms_to_sec(dat_i[28:24], dat_i[21:16], dat_i[13:8]);
                     end else begin
                        lt1_r <= hms_to_sec(dat_i[28:24], dat_i[21:16], dat_i[13:8]);
                     end
                     run_r[dat_i[`SCCL_C_LINE]] <= 1'b1;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // Tenth-second tick, seconds edge, step decisions
   always @(posedge clk_i) begin
      if (rst_i) begin
         div_r <= 23'h000000;
         tick_r <= 1'b0;
         tcnt_r <= 4'h0;
         sec_d_r <= 1'b0;
         step_r <= 2'b00;
         fault_d_r <= 1'b0;
      end else begin
         sec_d_r <= sec_s;
         fault_d_r <= fault_w;
         tick_r <= (div_r == `SCCL_TENTH_CYC - 23'h000001);
         div_r <= (div_r == `SCCL_TENTH_CYC - 23'h000001) ? 23'h000000 : div_r + 23'h000001;
         if (tick_r) begin
            tcnt_r <= (tcnt_r == `SCCL_TICKS_SEC - 4'h1) ? 4'h0 : tcnt_r + 4'h1;
         end
         // Step a minute line when its time lags the system time; hold under fault
         step_r[0] <= tick_r && tcnt_r == 4'h0 && run_r[0] && !fault_w && !busy_w[0] &&
                      lt1_r != sys_w;
         step_r[1] <= tick_r && tcnt_r == 4'h0 && run_r[1] && !fault_w && !busy_w[1] &&
                      lt2_r != sys_w;
      end
   end

   // Pulse generators, one per line
   sccl_pulse u_p1 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick_r),
      .start_i(step_r[0] && pulse_mode_w),
      .width_i(pw1_r),
      .busy_o(busy_w[0]),
      .pol_o(pol_w[0])
   );
   sccl_pulse u_p2 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick_r),
      .start_i(step_r[1] && pulse_mode_w),
      .width_i(minsec_w ? `SCCL_PW_SEC : pw2_r),
      .busy_o(busy_w[1]),
      .pol_o(pol_w[1])
   );

   // Outputs, interrupt status and bus answer
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
         irq_st_r <= 3'h0;
         irq_o <= 1'b0;
         alarm_relay_o <= 1'b0;
         line_drive_o <= 2'b00;
         line_pol_o <= 2'b00;
         timecode_en_o <= 2'b00;
      end else begin
         ack_o <= acc_w;
         alarm_relay_o <= !fault_w;
         line_drive_o <= pulse_mode_w ? busy_w : 2'b00;
         line_pol_o <= pol_w;
         timecode_en_o <= (!pulse_mode_w) ? run_r : 2'b00;
         // Status: bit0 fault rise, bit1 fault clear, bit2 sync second; set wins
         irq_st_r <= (irq_st_r & ~((acc_w && we_i && idx_w == `SCCL_ADR_IRQ) ? dat_i[2:0] : 3'h0))
                     | {sec_edge_w, fault_d_r && !fault_w, fault_w && !fault_d_r};
         irq_o <= |(irq_st_r & irq_mk_r);
         dat_o <= 32'h00000000;
         if (acc_w && !we_i) begin
            case (idx_w)
               `SCCL_ADR_MODE: dat_o <= {24'h000000, mode_r};
               `SCCL_ADR_RSVD: dat_o <= {24'h000000, rsvd_r};
               `SCCL_ADR_PW1: dat_o <= {27'h0000000, pw1_r};
               `SCCL_ADR_PW2: dat_o <= {27'h0000000, pw2_r};
               `SCCL_ADR_TIME1: dat_o <= {14'h0000, run_r[0], lt1_r};
               `SCCL_ADR_TIME2: dat_o <= {14'h0000, run_r[1], lt2_r};
               `SCCL_ADR_STAT: dat_o <= {26'h0000000, fault_w, flt_s, run_r[1]};
               `SCCL_ADR_IRQ: dat_o <= {29'h00000000, irq_st_r};
               `SCCL_ADR_MASK: dat_o <= {29'h00000000, irq_mk_r};
               default: dat_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: bench/sccl_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sccl_top_chk (
   // System
   input wire clk_i,
   input wire rst_i,
   // Bus
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [31:0] dat_o,
   input wire ack_o,
   // Faults and lines
   input wire radio_fail_i,
   input wire line1_fault_i,
   input wire line2_fault_i,
   input wire supply_fault_i,
   input wire [1:0] line_drive_o,
   input wire [1:0] timecode_en_o,
   input wire alarm_relay_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Bus answers
   property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack: assert property (p_ack) else $error("no ack after request");
   property p_ack_one; ack_o |=> !ack_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
   property p_dat; !ack_o |-> dat_o == 32'h0; endproperty
   a_dat: assert property (p_dat) else $error("read data outside ack");
   // Alarm relay follows the fault pins
   property p_flt;
      (line1_fault_i || line2_fault_i || supply_fault_i) [*5] |-> !alarm_relay_o;
   endproperty
   a_flt: assert property (p_flt) else $error("relay held in fault");
   property p_ok;
      (!radio_fail_i && !line1_fault_i && !line2_fault_i && !supply_fault_i) [*6]
         |-> alarm_relay_o;
   endproperty
   a_ok: assert property (p_ok) else $error("relay not energised");
   // Line mode outputs
   property p_mode; timecode_en_o != 2'h0 |-> line_drive_o == 2'h0; endproperty
   a_mode: assert property (p_mode) else $error("pulses in time code mode");
   property p_pulse; $rose(line_drive_o[0]) |-> line_drive_o[0] [*8]; endproperty
   a_pulse: assert property (p_pulse) else $error("line pulse too short");
   property p_run;
      $changed(timecode_en_o) |-> (ack_o && we_i) || $past(ack_o && we_i)
         || $past(ack_o && we_i, 2);
   endproperty
   a_run: assert property (p_run) else $error("run state changed unasked");
endmodule
bind sccl_top sccl_top_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .dat_o, .ack_o,
   .radio_fail_i, .line1_fault_i, .line2_fault_i, .supply_fault_i, .line_drive_o,
   .timecode_en_o, .alarm_relay_o);
`default_nettype wire

// file: bench/sccl_clocks.sv
`timescale 1ns/1ps
`default_nettype none
module sccl_clocks (
   // System
   input wire clk_i,
   input wire rst_i,
   // Line side
   input wire [1:0] line_drive_i,
   input wire [1:0] cut_i,
   output logic [1:0] fault_o,
   output logic [15:0] pulses_o
);
   logic drv_r;
   // A cut line reads back as a fault on its monitor input
   always @(posedge clk_i) begin
      fault_o <= rst_i ? 2'h0 : cut_i;
      drv_r <= line_drive_i[0];
      if (rst_i) begin
         pulses_o <= 16'h0;
      end else if (line_drive_i[0] && !drv_r) begin
         pulses_o <= pulses_o + 16'h1;
      end
   end
endmodule
`default_nettype wire

// file: bench/sccl_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sccl_top_tb_top;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic radio_fail_i = 0, supply_fault_i = 0;
   logic [5:0] adr_i = 0;
   logic [3:0] sel_i = 0;
   logic [31:0] dat_i = 0, rd;
   logic [1:0] cut = 0, lf;
   wire [31:0] dat_o;
   wire ack_o, alarm_relay_o, irq_o;
   wire [1:0] line_drive_o, line_pol_o, timecode_en_o;
   int miscompares = 0, check_count = 0, cyc_n = 0;
   initial forever #10 clk_i = ~clk_i;
   sccl_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
      .ack_o, .sys_utc_i(17'h0e10), .sys_local_i(17'h1c20), .sys_sec_i(1'b0),
      .radio_fail_i, .line1_fault_i(lf[0]), .line2_fault_i(lf[1]), .supply_fault_i,
      .line_drive_o, .line_pol_o, .timecode_en_o, .alarm_relay_o, .irq_o);
   sccl_clocks far (.clk_i, .rst_i, .line_drive_i(line_drive_o), .cut_i(cut),
      .fault_o(lf), .pulses_o());
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic bus cycle, held until ack
   task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hf;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 0; stb_i <= 0;
   endtask
   task close_out;
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task t_reset;
      wb(0, 6'h00, 0); chk(rd, 32'h40);
      wb(0, 6'h04, 0); chk(rd, 32'h0);
      wb(0, 6'h08, 0); chk(rd, 32'h2);
      wb(0, 6'h0c, 0); chk(rd, 32'h2);
      wb(0, 6'h14, 0); chk(rd, 32'h0);
      wb(0, 6'h24, 0); chk(rd, 32'h0);
      wb(0, 6'h3c, 0); chk(rd, 32'h0);
      chk(alarm_relay_o, 1);
      chk({line_drive_o, line_pol_o, timecode_en_o}, 6'h00);
      $display("reset test done");
   endtask
   task t_width;
      wb(1, 6'h08, 1); wb(0, 6'h08, 0); chk(rd, 32'h2);
      wb(1, 6'h08, 31); wb(0, 6'h08, 0); chk(rd, 32'h1e);
      wb(1, 6'h0c, 17); wb(0, 6'h08, 0); chk(rd, 32'h1e);
      wb(0, 6'h0c, 0); chk(rd, 32'h11);
      $display("width test done");
   endtask
   task t_lines;
      wb(1, 6'h00, 32'h0);
      wb(1, 6'h10, 32'h2); repeat (3) @(posedge clk_i); chk(timecode_en_o, 2'h1);
      wb(1, 6'h10, 32'h3); repeat (3) @(posedge clk_i); chk(timecode_en_o, 2'h3);
      wb(1, 6'h10, 32'h6); repeat (3) @(posedge clk_i); chk(timecode_en_o, 2'h2);
      wb(1, 6'h10, 32'h01020308); wb(0, 6'h14, 0); chk(rd, 32'h00020e8b);
      chk(timecode_en_o, 2'h3);
      wb(1, 6'h10, 32'h18000008); wb(0, 6'h14, 0); chk(rd, 32'h00020e8b);
      wb(1, 6'h00, 32'h40); repeat (3) @(posedge clk_i); chk(timecode_en_o, 2'h0);
      $display("line test done");
   endtask
   task t_fault;
      wb(1, 6'h24, 32'h1);
      radio_fail_i <= 1; repeat (8) @(posedge clk_i); chk(alarm_relay_o, 0);
      wb(0, 6'h1c, 0); chk(rd[5], 1);
      chk(irq_o, 1);
      wb(1, 6'h20, 32'h1); wb(0, 6'h20, 0); chk(rd[0], 0);
      chk(irq_o, 0);
      wb(1, 6'h00, 32'hc0); repeat (8) @(posedge clk_i); chk(alarm_relay_o, 1);
      radio_fail_i <= 0; cut <= 2'h1; repeat (8) @(posedge clk_i);
      chk(alarm_relay_o, 0);
      wb(0, 6'h14, 0); chk(rd, 32'h00020e8b);
      wb(1, 6'h24, 32'h0); cut <= 2'h0; repeat (8) @(posedge clk_i);
      chk(alarm_relay_o, 1);
      chk(irq_o, 0);
      wb(0, 6'h20, 0); chk(rd[1], 1);
      $display("fault test done");
   endtask
   // Bound on the whole run
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         miscompares++;
         close_out;
      end
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      t_reset;
      t_width;
      t_lines;
      t_fault;
      close_out;
   end
endmodule
`default_nettype wire
